// ### verilog/gtc_pkg.sv
// Behaviour
// RULE1: Each count step comes from the core clock (timer) or from rising edges of an external count input (counter).
// RULE2: A 32-bit count advances once per full cycle of a programmable 32-bit prescaler.
// RULE3: Four 32-bit match values are each compared against the running count.
// RULE4: A match can leave the counter running and may raise an interrupt flag.
// RULE5: A match can halt the counter and may raise an interrupt flag.
// RULE6: A match can return the counter to zero and may raise an interrupt flag.
// RULE7: Each match value has a shadow copy so that new values reach a PWM channel only at a period boundary.
// RULE8: Each of four match outputs goes low, goes high, toggles or holds on its match.
// RULE9: A chosen edge on a capture input copies the count into that input's 32-bit capture register and may raise a flag.
// RULE10: Only the first two match channels can issue timed DMA request pulses.
// RULE11: A selected capture event can clear both counter and prescaler, for pulse width measurement.
// RULE12: Up to three match channels give single-edge PWM, with the resetting match setting the period.
// RULE13: The prescaler counts steps up to its terminal value, then restarts and advances the counter.
// RULE14: A match occurs when count equals a match value; enabled events set flags that software clears.
package gtc_pkg;

  localparam int GTC_MATCH_NUM = 4;
  localparam int GTC_CAP_NUM   = 4;
  localparam int GTC_DMA_NUM   = 2;
  localparam int GTC_PWM_NUM   = 3;
  localparam int GTC_FLAG_NUM  = GTC_MATCH_NUM + GTC_CAP_NUM;

  // match output actions
  localparam logic [1:0] GTC_ACT_NONE   = 2'h0;
  localparam logic [1:0] GTC_ACT_LOW    = 2'h1;
  localparam logic [1:0] GTC_ACT_HIGH   = 2'h2;
  localparam logic [1:0] GTC_ACT_TOGGLE = 2'h3;

  // values after reset and step size
  localparam logic [31:0] GTC_WORD_RST = 32'h0000_0000;
  localparam logic [31:0] GTC_STEP     = 32'h0000_0001;
  localparam logic [7:0]  GTC_FLAG_RST = 8'h00;

  typedef enum logic {
    GTC_STOPPED = 1'b0,
    GTC_RUNNING = 1'b1
  } gtc_run_t;

  typedef enum logic {
    GTC_SRC_TIMER   = 1'b0,
    GTC_SRC_COUNTER = 1'b1
  } gtc_src_t;

  typedef struct packed {
    logic       irq_en;
    logic       reset_en;
    logic       stop_en;
    logic       dma_en;
    logic       pwm_en;
    logic [1:0] ext_act;
  } gtc_mctl_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic irq_en;
  } gtc_ccfg_t;

  typedef struct packed {
    gtc_src_t   src;
    logic       cap_clear_en;
    logic [1:0] cap_clear_sel;
  } gtc_cfg_t;

endpackage : gtc_pkg

// ### verilog/gtc_timer.sv
`timescale 1ns/1ps
module gtc_timer (
  // clock and reset
  input  logic                                        i_core_clk,
  input  logic                                        i_reset_n,
  // run control
  input  logic                                        i_start,
  input  logic                                        i_halt,
  input  logic                                        i_counter_reset,
  input  gtc_pkg::gtc_cfg_t                           i_cfg,
  input  logic [31:0]                                 i_prescale_max,
  input  logic                                        i_ext_count,
  // match channels
  input  logic [gtc_pkg::GTC_MATCH_NUM-1:0]           i_match_wr,
  input  logic [31:0]                                 i_match_data,
  input  gtc_pkg::gtc_mctl_t [gtc_pkg::GTC_MATCH_NUM-1:0] i_mctl,
  // capture channels
  input  logic [gtc_pkg::GTC_CAP_NUM-1:0]             i_cap,
  input  gtc_pkg::gtc_ccfg_t [gtc_pkg::GTC_CAP_NUM-1:0] i_cap_cfg,
  // status clear
  input  logic [gtc_pkg::GTC_FLAG_NUM-1:0]            i_flag_clr,
  // state and results
  output gtc_pkg::gtc_run_t                           o_run_state,
  output logic [31:0]                                 o_count,
  output logic [31:0]                                 o_prescale,
  output logic [gtc_pkg::GTC_CAP_NUM-1:0][31:0]       o_capture,
  output logic [gtc_pkg::GTC_FLAG_NUM-1:0]            o_flags,
  output logic [gtc_pkg::GTC_MATCH_NUM-1:0]           o_match_out,
  output logic [gtc_pkg::GTC_DMA_NUM-1:0]             o_dma_req
);
  import gtc_pkg::*;

  logic                     ext_prev;
  logic [GTC_CAP_NUM-1:0]   cap_prev;
  logic                     tick;
  logic                     term;
  logic                     any_reset;
  logic                     any_stop;
  logic                     cap_clear;
  logic [GTC_MATCH_NUM-1:0] match_hit;
  logic [GTC_MATCH_NUM-1:0] rst_hit;
  logic [GTC_MATCH_NUM-1:0] stop_hit;
  logic [GTC_MATCH_NUM-1:0] match_set;
  logic [GTC_CAP_NUM-1:0]   cap_edge;
  logic [GTC_CAP_NUM-1:0]   cap_set;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  // previous input levels for edge detection
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_prev <= 1'b0;
      cap_prev <= '0;
    end else begin
      ext_prev <= i_ext_count;
      cap_prev <= i_cap;
    end
  end

  // the external source counts rising edges only; it must stay below
  // half the core clock rate or edges are lost
  assign tick = (o_run_state == GTC_RUNNING) &
                ((i_cfg.src == GTC_SRC_TIMER) |
                 (i_ext_count & ~ext_prev)); // [RULE1]
  assign term = tick & (o_prescale == i_prescale_max); // [RULE13]
  assign any_reset = |rst_hit;
  assign any_stop  = |stop_hit;
  assign cap_clear = i_cfg.cap_clear_en &
                     cap_edge[i_cfg.cap_clear_sel]; // [RULE11]

  // prescaler and main counter
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prescale <= GTC_WORD_RST;
      o_count    <= GTC_WORD_RST;
    end else if (i_counter_reset | cap_clear) begin
      o_prescale <= GTC_WORD_RST; // [RULE11]
      o_count    <= GTC_WORD_RST;
    end else if (term) begin
      o_prescale <= GTC_WORD_RST; // [RULE13]
      if (any_reset) begin
        o_count <= GTC_WORD_RST; // [RULE6]
      end else if (!any_stop) begin
        o_count <= o_count + GTC_STEP; // [RULE2] [RULE4]
      end
    end else if (tick) begin
      o_prescale <= o_prescale + GTC_STEP; // [RULE13]
    end
  end

  // stop on match holds the count at the matching value unless a clear or a reset on match zeroes it in the same cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_run_state <= GTC_STOPPED;
    end else begin
      case (o_run_state)
        GTC_STOPPED: begin
          if (i_start) begin
            o_run_state <= GTC_RUNNING;
          end
        end
        GTC_RUNNING: begin
          if (i_halt | any_stop) begin
            o_run_state <= GTC_STOPPED; // [RULE5]
          end
        end
        default: begin
          o_run_state <= GTC_STOPPED;
        end
      endcase
    end
  end

  genvar i;
  generate
    for (i = 0; i < GTC_MATCH_NUM; i++) begin : g_match
      localparam logic PWM_OK = (i < GTC_PWM_NUM);
      logic [31:0] shadow;
      logic [31:0] active;
      logic        out_q;
      logic        pwm_on;

      assign pwm_on = i_mctl[i].pwm_en & PWM_OK; // [RULE12]

      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          shadow <= GTC_WORD_RST;
        end else if (i_match_wr[i]) begin
          shadow <= i_match_data; // [RULE7]
        end
      end

      // a pwm channel only picks up the shadow at the period reset,
      // so a mid-period write cannot cause a runt pulse
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          active <= GTC_WORD_RST;
        end else if (!pwm_on && i_match_wr[i]) begin
          active <= i_match_data;
        end else if (pwm_on && any_reset) begin
          active <= shadow; // [RULE7]
        end
      end

      assign match_hit[i] = term & (o_count == active); // [RULE3] [RULE14]
      assign rst_hit[i]   = match_hit[i] & i_mctl[i].reset_en; // [RULE6]
      assign stop_hit[i]  = match_hit[i] & i_mctl[i].stop_en; // [RULE5]
      assign match_set[i] = match_hit[i] & i_mctl[i].irq_en; // [RULE4]

      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          out_q <= 1'b0;
        end else if (pwm_on) begin
          if (match_hit[i]) begin
            out_q <= 1'b1; // [RULE12]
          end else if (any_reset) begin
            out_q <= 1'b0;
          end
        end else if (match_hit[i]) begin
          case (i_mctl[i].ext_act)
            GTC_ACT_NONE:   out_q <= out_q; // [RULE8]
            GTC_ACT_LOW:    out_q <= 1'b0;
            GTC_ACT_HIGH:   out_q <= 1'b1;
            GTC_ACT_TOGGLE: out_q <= ~out_q;
            default:        out_q <= out_q;
          endcase
        end
      end
      assign o_match_out[i] = out_q;

      if (i < GTC_DMA_NUM) begin : g_dma
        logic dma_q;
        always_ff @(posedge i_core_clk or negedge i_reset_n) begin
          if (!i_reset_n) begin
            dma_q <= 1'b0;
          end else begin
            dma_q <= match_hit[i] & i_mctl[i].dma_en; // [RULE10]
          end
        end
        assign o_dma_req[i] = dma_q;
      end
    end

    for (i = 0; i < GTC_CAP_NUM; i++) begin : g_cap
      logic [31:0] cap_q;
      assign cap_edge[i] = (i_cap_cfg[i].rise & i_cap[i] & ~cap_prev[i]) |
                           (i_cap_cfg[i].fall & ~i_cap[i] & cap_prev[i]);
      assign cap_set[i]  = cap_edge[i] & i_cap_cfg[i].irq_en;

      // the value taken is the count before any clear in the same cycle
      always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          cap_q <= GTC_WORD_RST;
        end else if (cap_edge[i]) begin
          cap_q <= o_count; // [RULE9]
        end
      end
      assign o_capture[i] = cap_q;
    end
  endgenerate

  // set wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flags <= GTC_FLAG_RST;
    end else begin
      o_flags <= (o_flags & ~i_flag_clr) | {cap_set, match_set}; // [RULE14]
    end
  end

  a_prescale_wrap: assert property ( // [RULE13]
    term && !cap_clear && !i_counter_reset |=> o_prescale == GTC_WORD_RST)
    else $error("prescaler did not restart at terminal value");

  a_count_step: assert property ( // [RULE2]
    term && !cap_clear && !i_counter_reset && !any_reset && !any_stop
    |=> o_count == $past(o_count) + GTC_STEP)
    else $error("count did not advance after prescaler terminal");

  a_idle_hold: assert property ( // [RULE1]
    !tick && !cap_clear && !i_counter_reset
    |=> $stable(o_count) && $stable(o_prescale))
    else $error("counter moved without a count step");

  a_match_reset: assert property ( // [RULE6]
    any_reset |=> o_count == GTC_WORD_RST)
    else $error("reset on match did not clear count");

  a_match_stop: assert property ( // [RULE5]
    any_stop |=> o_run_state == GTC_STOPPED ##1 $stable(o_count))
    else $error("stop on match did not halt counter");

  a_match_flag: assert property ( // [RULE4]
    match_hit[0] && i_mctl[0].irq_en |=> o_flags[0])
    else $error("match flag not set");

  a_capture_latch: assert property ( // [RULE9]
    cap_edge[0] |=> o_capture[0] == $past(o_count))
    else $error("capture did not latch count");

  a_capture_clear: assert property ( // [RULE11]
    cap_clear |=> o_count == GTC_WORD_RST && o_prescale == GTC_WORD_RST)
    else $error("capture clear did not clear counter and prescaler");

  a_dma_pulse: assert property ( // [RULE10]
    match_hit[1] && i_mctl[1].dma_en |=> o_dma_req[1])
    else $error("dma request missing after match");

  a_out_toggle: assert property ( // [RULE8]
    match_hit[0] && !g_match[0].pwm_on &&
    i_mctl[0].ext_act == GTC_ACT_TOGGLE
    |=> o_match_out[0] != $past(o_match_out[0]))
    else $error("match output did not toggle");

  a_shadow_hold: assert property ( // [RULE7]
    g_match[0].pwm_on && !any_reset |=> $stable(g_match[0].active))
    else $error("pwm match value changed mid period");

  a_pwm_period: assert property ( // [RULE12]
    g_match[0].pwm_on && any_reset && !match_hit[0] |=> !o_match_out[0])
    else $error("pwm output not low at period start");

  a_dma_idle: assert property ( // [RULE10]
    !(match_hit[0] && i_mctl[0].dma_en) |=> !o_dma_req[0])
    else $error("dma request without a match");

  a_halt_stop: assert property ( // [RULE5]
    o_run_state == GTC_RUNNING && i_halt |=> o_run_state == GTC_STOPPED)
    else $error("halt did not stop the counter");

  a_stopped_hold: assert property ( // [RULE5]
    o_run_state == GTC_STOPPED && !i_counter_reset && !cap_clear
    |=> $stable(o_count) && $stable(o_prescale))
    else $error("stopped counter moved");

  a_flag_clear: assert property ( // [RULE14]
    i_flag_clr[0] && !match_set[0] |=> !o_flags[0])
    else $error("match flag not cleared");

  a_flag_sticky: assert property ( // [RULE14]
    o_flags[0] && !i_flag_clr[0] |=> o_flags[0])
    else $error("match flag dropped without a clear");

  a_capture_flag: assert property ( // [RULE9]
    cap_set[0] |=> o_flags[GTC_MATCH_NUM])
    else $error("capture flag not set");

  a_out_high: assert property ( // [RULE8]
    match_hit[1] && !g_match[1].pwm_on &&
    i_mctl[1].ext_act == GTC_ACT_HIGH |=> o_match_out[1])
    else $error("match output did not go high");

  a_pwm_set: assert property ( // [RULE12]
    g_match[0].pwm_on && match_hit[0] |=> o_match_out[0])
    else $error("pwm output not high after its match");

  a_ext_edge: assert property ( // [RULE1]
    i_cfg.src == GTC_SRC_COUNTER && !(i_ext_count && !ext_prev) &&
    !cap_clear && !i_counter_reset
    |=> $stable(o_prescale) && $stable(o_count))
    else $error("counter mode moved without an external edge");

  c_period_reset: cover property (any_reset ##[1:50] any_reset);
  c_stop_match: cover property (any_stop);
  c_capture_clear: cover property (cap_clear);
  c_dma_request: cover property (o_dma_req[0]);
  c_pwm_high: cover property (g_match[0].pwm_on && o_match_out[0]);

endmodule : gtc_timer

// ### dv/gtc_far_model.sv
`timescale 1ns/1ps
module gtc_far_model (
  // clock
  input  wire logic       i_core_clk,
  // match pins seen from outside
  input  wire logic [3:0] i_match_out,
  // stimulus towards the timer
  output logic      [3:0] o_cap,
  output logic            o_ext_count
);
  int pin_changes;
  logic [3:0] last_out;
  initial begin
    o_cap       = 4'h0;
    o_ext_count = 1'h0;
    pin_changes = 0;
    last_out    = 4'h0;
  end
  // counts output pin transitions as a board would see them; sampled
  // on the falling edge so the pins have settled
  always @(negedge i_core_clk) begin
    if (i_match_out !== last_out) pin_changes++;
    last_out <= i_match_out;
  end
  // one cycle high, two low, so every pulse is a clean rising edge
  task automatic pulse_ext(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      o_ext_count <= 1'h1;
      @(posedge i_core_clk);
      o_ext_count <= 1'h0;
      @(posedge i_core_clk);
    end
  endtask : pulse_ext
  task automatic drive_cap(input int j, input logic v);
    @(posedge i_core_clk);
    o_cap[j] <= v;
  endtask : drive_cap
endmodule : gtc_far_model

// ### dv/test_general_timer_counter_32bit.sv
`timescale 1ns/1ps
module test_general_timer_counter_32bit;
  import gtc_pkg::*;
  logic                   clk, rst_n, start, halt, creset, ext;
  gtc_cfg_t               cfg;
  logic [31:0]            pmax, mdata, cnt, pre;
  logic [3:0]             mwr, cap, mout;
  gtc_mctl_t [3:0]        mctl;
  gtc_ccfg_t [3:0]        ccfg;
  logic [7:0]             fclr, flags;
  gtc_run_t               run;
  logic [3:0][31:0]       capt;
  logic [1:0]             dma;
  logic                   o0;
  int                     err_count, cmp_count;

  gtc_timer DUT (.i_core_clk(clk), .i_reset_n(rst_n), .i_start(start),
    .i_halt(halt), .i_counter_reset(creset), .i_cfg(cfg),
    .i_prescale_max(pmax), .i_ext_count(ext), .i_match_wr(mwr),
    .i_match_data(mdata), .i_mctl(mctl), .i_cap(cap), .i_cap_cfg(ccfg),
    .i_flag_clr(fclr), .o_run_state(run), .o_count(cnt),
    .o_prescale(pre), .o_capture(capt), .o_flags(flags),
    .o_match_out(mout), .o_dma_req(dma));
  gtc_far_model far (.i_core_clk(clk), .i_match_out(mout), .o_cap(cap),
    .o_ext_count(ext));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // stop, clear count and flags, then run again from zero
  task automatic restart(input logic [31:0] p);
    @(posedge clk);
    halt <= 1'h1; creset <= 1'h1; fclr <= 8'hff;
    @(posedge clk);
    halt <= 1'h0; creset <= 1'h0; fclr <= 8'h00; pmax <= p; start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
  endtask : restart
  task automatic wr_match(input int j, input logic [31:0] v);
    @(posedge clk);
    mwr <= 4'h1 << j; mdata <= v;
    @(posedge clk);
    mwr <= 4'h0;
  endtask : wr_match

  task automatic s_prescale();
    restart(32'h0000_0002);
    tick(10);
    chk_word("count", 32'h0000_0003, cnt);
    chk_word("prescale", 32'h0000_0001, pre);
  endtask : s_prescale
  task automatic s_match_reset();
    @(posedge clk);
    mctl[0] <= '{irq_en:1'h1, reset_en:1'h1, dma_en:1'h1,
                 ext_act:GTC_ACT_TOGGLE, default:'0};
    wr_match(0, 32'h0000_0003);
    #1 o0 = mout[0];
    restart(32'h0000_0000);
    tick(4);
    chk_word("count", 32'h0000_0000, cnt);
    chk_bit("flag0", 1'h1, flags[0]);
    chk_bit("dma0", 1'h1, dma[0]);
    chk_bit("out0", ~o0, mout[0]);
    tick(1);
    chk_bit("dma0", 1'h0, dma[0]);
    @(posedge clk) fclr <= 8'h01;
    @(posedge clk) fclr <= 8'h00;
    #1;
    chk_bit("flag0", 1'h0, flags[0]);
    tick(1);
    chk_bit("out0", o0, mout[0]);
  endtask : s_match_reset
  task automatic s_stop();
    @(posedge clk);
    mctl[0] <= '{irq_en:1'h1, default:'0};
    mctl[1] <= '{irq_en:1'h1, stop_en:1'h1, dma_en:1'h1,
                 ext_act:GTC_ACT_HIGH, default:'0};
    wr_match(1, 32'h0000_0005);
    restart(32'h0000_0001);
    tick(14);
    chk_bit("run", GTC_STOPPED, run);
    chk_word("count", 32'h0000_0005, cnt);
    chk_word("flags", 32'h0000_0003, {24'h0, flags});
    chk_bit("out1", 1'h1, mout[1]);
  endtask : s_stop
  task automatic s_capture();
    @(posedge clk);
    ccfg[0] <= '{rise:1'h1, fall:1'h0, irq_en:1'h1};
    ccfg[1] <= '{rise:1'h0, fall:1'h1, irq_en:1'h0};
    cfg.cap_clear_en <= 1'h1; cfg.cap_clear_sel <= 2'h1;
    mctl <= '0;
    restart(32'h0000_0003);
    tick(8);
    far.drive_cap(0, 1'h1);
    tick(3);
    chk_word("capture0", 32'h0000_0002, capt[0]);
    chk_bit("flag4", 1'h1, flags[4]);
    far.drive_cap(1, 1'h1);
    tick(2);
    chk_word("count", 32'h0000_0003, cnt);
    far.drive_cap(1, 1'h0);
    tick(3);
    chk_word("count", 32'h0000_0000, cnt);
    chk_word("prescale", 32'h0000_0002, pre);
    far.drive_cap(0, 1'h0);
    cfg.cap_clear_en <= 1'h0;
  endtask : s_capture
  task automatic s_counter();
    @(posedge clk);
    cfg.src <= GTC_SRC_COUNTER; mctl <= '0;
    restart(32'h0000_0000);
    far.pulse_ext(5);
    tick(3);
    chk_word("count", 32'h0000_0005, cnt);
  endtask : s_counter
  // ch3 sets a six-count period, ch0 is the pwm channel; the new value
  // written mid period must wait for the next period start
  task automatic s_pwm();
    int pc0;
    @(posedge clk);
    cfg.src <= GTC_SRC_TIMER;
    mctl[0] <= '{pwm_en:1'h1, default:'0};
    mctl[3] <= '{reset_en:1'h1, default:'0};
    wr_match(0, 32'h0000_0002);
    wr_match(3, 32'h0000_0005);
    restart(32'h0000_0000);
    tick(5);
    pc0 = far.pin_changes;
    chk_bit("pwm0", 1'h1, mout[0]);
    wr_match(0, 32'h0000_0004);
    tick(2);
    chk_bit("pwm0", 1'h1, mout[0]);
    tick(3);
    chk_bit("pwm0", 1'h0, mout[0]);
    tick(4);
    chk_bit("pwm0", 1'h0, mout[0]);
    tick(1);
    chk_bit("pwm0", 1'h1, mout[0]);
    chk_word("pin changes", 32'h0000_0003, far.pin_changes - pc0);
  endtask : s_pwm

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    rst_n = 1'h0; start = 1'h0; halt = 1'h0; creset = 1'h0; cfg = '0;
    pmax = '0; mdata = '0; mwr = '0; mctl = '0; ccfg = '0; fclr = '0;
    err_count = 0; cmp_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    s_prescale();
    s_match_reset();
    s_stop();
    s_capture();
    s_counter();
    s_pwm();
    complete_run();
  end
endmodule : test_general_timer_counter_32bit
